/* File: pkg/lts_pkg.sv */
// Purpose: shared constants for the lane test and status block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   byte addresses are used directly on paddr
`default_nettype none
package lts_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] LTS_OFF_CTRL = 8'h00;
   localparam logic [7:0] LTS_OFF_BOOST = 8'h04;
   localparam logic [7:0] LTS_OFF_STATUS = 8'h08;
   localparam logic [7:0] LTS_OFF_ERRCNT = 8'h0C;
   localparam logic [7:0] LTS_OFF_IRQST = 8'h10;
   localparam logic [7:0] LTS_OFF_IRQMASK = 8'h14;

   // ==========================================================
   // control register fields
   localparam int LTS_CTRL_EQRST = 0;
   localparam int LTS_CTRL_HFREEZE = 1;
   localparam int LTS_CTRL_HOVR = 2;
   localparam int LTS_CTRL_LFREEZE = 3;
   localparam int LTS_CTRL_LOVR = 4;
   localparam int LTS_CTRL_TXBLOCK = 5;
   localparam int LTS_CTRL_CDRFREEZE = 6;
   localparam int LTS_CTRL_FORCEERR = 7;
   localparam int LTS_CTRL_CNTCLR = 8;
   localparam int LTS_CTRL_GENSEL = 16;
   localparam int LTS_CTRL_CHKSEL = 20;
   localparam logic [31:0] LTS_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] LTS_CTRL_MASK = 32'h0077_01FF;

   // ==========================================================
   // boost register, status and interrupt fields
   localparam int LTS_BOOST_HIGH = 0;
   localparam int LTS_BOOST_LOW = 8;
   localparam logic [15:0] LTS_BOOST_RESET = 16'h0000;
   localparam int LTS_ST_PATERR = 0;
   localparam int LTS_ST_DISP = 4;
   localparam int LTS_ST_INVAL = 8;
   localparam int LTS_ST_COMMA = 12;
   localparam int LTS_IRQ_PATERR = 0;
   localparam int LTS_IRQ_DISP = 1;
   localparam int LTS_IRQ_INVAL = 2;
   localparam int LTS_IRQ_COMMA = 3;
   localparam logic [3:0] LTS_IRQ_RESET = 4'h0;

   // ==========================================================
   // pattern select encodings and the shared PRBS seed
   localparam logic [2:0] LTS_PAT_OFF = 3'h0;
   localparam logic [2:0] LTS_PAT_PRBS7 = 3'h1;
   localparam logic [2:0] LTS_PAT_PRBS15 = 3'h2;
   localparam logic [2:0] LTS_PAT_PRBS23 = 3'h3;
   localparam logic [2:0] LTS_PAT_PRBS31 = 3'h4;
   localparam logic [30:0] LTS_SEED = 31'h7FFF_FFFF;
endpackage
`default_nettype wire

/* File: hdl/lts_lane_test_status.sv */
// Purpose: lane 0 test, equalizer control and status logic behind an APB slave
// Assumes: all lane-side inputs synchronous to clk; zero-wait APB answers
// Notes:   pattern generator and checker handle 32 bits per clock
//
// Overview of operation
// - software pulses the equalizer reset bit high then low and the falling edge starts a reset.
// - each boost freeze bit either holds its boost value or lets it follow its source.
// - each boost override bit picks the live register value or the static attribute as source.
// - while transmit block is set the lane transmits zeros and resumes once it clears.
// - setting the checker count clear bit zeroes the pattern error counter.
// - the pattern error flag is high only for words that currently mismatch.
// - a three-bit checker select picks the sequence the receive checker expects.
// - a three-bit generator select picks the sequence the transmit generator sends.
// - while force error is held the generated word carries a flipped bit every cycle.
// - while recovery loop freeze is set the recovery loop hold output is asserted.
// - a four-bit flag shows a running disparity error on each received byte.
// - a four-bit flag shows each received byte that was not a legal 8B/10B character.
// - the comma found output goes high when the aligner reports a comma.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lts_lane_test_status
   import lts_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter logic [7:0] HIGH_BOOST_ATTR = 8'h00,
   parameter logic [7:0] LOW_BOOST_ATTR = 8'h00
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // transmit path
   input wire logic [31:0] txUserData,
   output logic [31:0] laneTxData,
   // receive path from decoder and aligner
   input wire logic [31:0] laneRxData,
   input wire logic [3:0] rxDisparityIn,
   input wire logic [3:0] rxInvalidCodeIn,
   input wire logic rxCommaIn,
   // lane controls and status
   output logic lane0EqualizerResetStart,
   output logic [7:0] lane0HighBoost,
   output logic [7:0] lane0LowBoost,
   output logic lane0RecoveryLoopFreeze,
   output logic lane0PatternErrorFlag,
   output logic [3:0] lane0ByteDisparityFlags,
   output logic [3:0] lane0ByteInvalidCodeFlags,
   output logic lane0CommaFound
);

   // ==========================================================
   // state record
   typedef struct packed {
      logic [31:0] ctrl;
      logic [15:0] boost;
      logic [3:0] irqStatus;
      logic [3:0] irqMask;
      logic [31:0] rdata;
      logic ready;
      logic slvErr;
      logic irqOut;
      logic eqResetPrev;
      logic eqResetStart;
      logic [7:0] highBoost;
      logic [7:0] lowBoost;
      logic cdrFreeze;
      logic [30:0] genState;
      logic [31:0] txData;
      logic [30:0] chkState;
      logic patErr;
      logic [CNT_W-1:0] errCount;
      logic [3:0] dispFlags;
      logic [3:0] invalFlags;
      logic comma;
   } lts_state_t;

   lts_state_t stateReg;
   lts_state_t stateNext;

   // ==========================================================
   // pattern helpers
   // feedback bit for the selected polynomial
   function automatic logic ltsFeedback(input logic [30:0] st, input logic [2:0] sel);
      logic fb;
      fb = 1'b0;
      case (sel)
         LTS_PAT_PRBS7: fb = st[6] ^ st[5];
         LTS_PAT_PRBS15: fb = st[14] ^ st[13];
         LTS_PAT_PRBS23: fb = st[22] ^ st[17];
         LTS_PAT_PRBS31: fb = st[30] ^ st[27];
         default: fb = 1'b0;
      endcase
      return fb;
   endfunction

   // advance 32 bits; returns {next state, predicted word}
   // in feed mode the received bits enter the register so the checker self-aligns
   function automatic logic [62:0] ltsAdvance(input logic [30:0] st, input logic [2:0] sel,
                                              input logic feed, input logic [31:0] rx);
      logic [30:0] s;
      logic [31:0] word;
      logic b;
      s = (st == 31'h0000_0000) ? LTS_SEED : st; // escape the lock-up state
      word = 32'h0000_0000;
      b = 1'b0;
      for (int i = 0; i < 32; i++) begin
         b = ltsFeedback(s, sel);
         word[31-i] = b;
         s = {s[29:0], (feed ? rx[31-i] : b)};
      end
      return {s, word};
   endfunction

   // ==========================================================
   // combinational next state
   always_comb begin
      logic [62:0] genAdv;
      logic [62:0] chkAdv;
      logic [2:0] genSel;
      logic [2:0] chkSel;
      logic [31:0] txWord;
      logic mismatch;
      logic wrEn;
      logic rdSetup;
      logic [3:0] w1c;
      logic [3:0] events;
      logic [7:0] highSrc;
      logic [7:0] lowSrc;
      genAdv = 63'h0;
      chkAdv = 63'h0;
      genSel = 3'h0;
      chkSel = 3'h0;
      txWord = 32'h0000_0000;
      mismatch = 1'b0;
      w1c = 4'h0;
      events = 4'h0;
      highSrc = 8'h00;
      lowSrc = 8'h00;
      stateNext = stateReg;

      // apb decode: answer prepared in setup, write lands in access
      wrEn = psel & penable & pwrite & stateReg.ready;
      rdSetup = psel & ~penable;
      stateNext.ready = rdSetup;
      stateNext.slvErr = 1'b0;
      stateNext.rdata = 32'h0000_0000;
      if (rdSetup) begin
         case (paddr)
            LTS_OFF_CTRL: stateNext.rdata = stateReg.ctrl;
            LTS_OFF_BOOST: stateNext.rdata = {16'h0000, stateReg.boost};
            LTS_OFF_STATUS: begin
               stateNext.rdata[LTS_ST_PATERR] = stateReg.patErr;
               stateNext.rdata[LTS_ST_DISP +: 4] = stateReg.dispFlags;
               stateNext.rdata[LTS_ST_INVAL +: 4] = stateReg.invalFlags;
               stateNext.rdata[LTS_ST_COMMA] = stateReg.comma;
            end
            LTS_OFF_ERRCNT: stateNext.rdata[CNT_W-1:0] = stateReg.errCount;
            LTS_OFF_IRQST: stateNext.rdata[3:0] = stateReg.irqStatus;
            LTS_OFF_IRQMASK: stateNext.rdata[3:0] = stateReg.irqMask;
            default: stateNext.slvErr = 1'b1; // unmapped: reads zero, error
         endcase
      end
      if (wrEn) begin
         case (paddr)
            LTS_OFF_CTRL: stateNext.ctrl = pwdata & LTS_CTRL_MASK;
            LTS_OFF_BOOST: stateNext.boost = pwdata[15:0];
            LTS_OFF_IRQST: w1c = pwdata[3:0];
            LTS_OFF_IRQMASK: stateNext.irqMask = pwdata[3:0];
            default: w1c = 4'h0;
         endcase
      end

      // equalizer reset starts on the falling edge of the software pulse
      stateNext.eqResetPrev = stateReg.ctrl[LTS_CTRL_EQRST];
      stateNext.eqResetStart = stateReg.eqResetPrev & ~stateReg.ctrl[LTS_CTRL_EQRST];

      // boost source select, then freeze or follow
      highSrc = stateReg.ctrl[LTS_CTRL_HOVR] ? stateReg.boost[LTS_BOOST_HIGH +: 8]
                                             : HIGH_BOOST_ATTR;
      lowSrc = stateReg.ctrl[LTS_CTRL_LOVR] ? stateReg.boost[LTS_BOOST_LOW +: 8]
                                            : LOW_BOOST_ATTR;
      if (!stateReg.ctrl[LTS_CTRL_HFREEZE]) begin
         stateNext.highBoost = highSrc;
      end
      if (!stateReg.ctrl[LTS_CTRL_LFREEZE]) begin
         stateNext.lowBoost = lowSrc;
      end

      // recovery loop hold follows its control bit
      stateNext.cdrFreeze = stateReg.ctrl[LTS_CTRL_CDRFREEZE];

      // transmit generator
      genSel = stateReg.ctrl[LTS_CTRL_GENSEL +: 3];
      if (genSel == LTS_PAT_OFF || genSel > LTS_PAT_PRBS31) begin
         txWord = txUserData;
         stateNext.genState = LTS_SEED;
      end else begin
         genAdv = ltsAdvance(stateReg.genState, genSel, 1'b0, 32'h0000_0000);
         stateNext.genState = genAdv[62:32];
         txWord = genAdv[31:0];
      end
      if (stateReg.ctrl[LTS_CTRL_FORCEERR]) begin
         txWord[0] = ~txWord[0];
      end
      stateNext.txData = stateReg.ctrl[LTS_CTRL_TXBLOCK] ? 32'h0000_0000 : txWord;

      // receive checker: prediction from past bits against this word
      chkSel = stateReg.ctrl[LTS_CTRL_CHKSEL +: 3];
      if (chkSel == LTS_PAT_OFF || chkSel > LTS_PAT_PRBS31) begin
         stateNext.chkState = LTS_SEED;
      end else begin
         chkAdv = ltsAdvance(stateReg.chkState, chkSel, 1'b1, laneRxData);
         stateNext.chkState = chkAdv[62:32];
         mismatch = (chkAdv[31:0] != laneRxData);
      end
      stateNext.patErr = mismatch;
      if (stateReg.ctrl[LTS_CTRL_CNTCLR]) begin
         stateNext.errCount = '0;
      end else if (mismatch && !(&stateReg.errCount)) begin
         stateNext.errCount = stateReg.errCount + 1'b1;
      end

      // per-byte decoder status and comma
      stateNext.dispFlags = rxDisparityIn;
      stateNext.invalFlags = rxInvalidCodeIn;
      stateNext.comma = rxCommaIn;

      // sticky interrupt status: a new event wins over a clear
      events[LTS_IRQ_PATERR] = mismatch;
      events[LTS_IRQ_DISP] = |rxDisparityIn;
      events[LTS_IRQ_INVAL] = |rxInvalidCodeIn;
      events[LTS_IRQ_COMMA] = rxCommaIn;
      stateNext.irqStatus = (stateReg.irqStatus & ~w1c) | events;
      stateNext.irqOut = |(stateNext.irqStatus & stateNext.irqMask);
   end

   // ==========================================================
   // state register with clock enable and synchronous reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stateReg <= '0;
         stateReg.ctrl <= LTS_CTRL_RESET;
         stateReg.boost <= LTS_BOOST_RESET;
         stateReg.irqStatus <= LTS_IRQ_RESET;
         stateReg.irqMask <= LTS_IRQ_RESET;
         stateReg.highBoost <= HIGH_BOOST_ATTR;
         stateReg.lowBoost <= LOW_BOOST_ATTR;
         stateReg.genState <= LTS_SEED;
         stateReg.chkState <= LTS_SEED;
      end else if (clkEn) begin
         stateReg <= stateNext;
      end
   end

   // ==========================================================
   // outputs straight from the state register
   assign prdata = stateReg.rdata;
   assign pready = stateReg.ready;
   assign pslverr = stateReg.slvErr;
   assign irq = stateReg.irqOut;
   assign laneTxData = stateReg.txData;
   assign lane0EqualizerResetStart = stateReg.eqResetStart;
   assign lane0HighBoost = stateReg.highBoost;
   assign lane0LowBoost = stateReg.lowBoost;
   assign lane0RecoveryLoopFreeze = stateReg.cdrFreeze;
   assign lane0PatternErrorFlag = stateReg.patErr;
   assign lane0ByteDisparityFlags = stateReg.dispFlags;
   assign lane0ByteInvalidCodeFlags = stateReg.invalFlags;
   assign lane0CommaFound = stateReg.comma;

endmodule
`default_nettype wire

/* File: bench/lts_lane_test_status_asserts.sv */
// Purpose: port checks for the lane test and status block
// Assumes: control word is shadowed from apb writes at the access edge
// Notes:   lane-side copies are checked one cycle late
`timescale 1ns/1ps
`default_nettype none
module lts_lane_test_status_asserts (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [31:0] txUserData,
   input wire logic [31:0] laneTxData,
   input wire logic [3:0] rxDisparityIn,
   input wire logic [3:0] rxInvalidCodeIn,
   input wire logic rxCommaIn,
   input wire logic lane0EqualizerResetStart,
   input wire logic lane0RecoveryLoopFreeze,
   input wire logic [3:0] lane0ByteDisparityFlags,
   input wire logic [3:0] lane0ByteInvalidCodeFlags,
   input wire logic lane0CommaFound
);
   logic [31:0] ctl_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // shadow of the control word, updated where the slave stores it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctl_reg <= 32'h0;
      end else if (clkEn && psel && penable && pready && pwrite && paddr == 8'h00) begin
         ctl_reg <= pwdata;
      end
   end
   // ==========================================================
   // checks
   apb_ready_a: assert property (psel && !penable && clkEn |=> pready)
      else $error("no ready after setup");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   tx_block_a: assert property (clkEn && ctl_reg[5] |=> laneTxData == 32'h0)
      else $error("lane sends while blocked");
   tx_follow_a: assert property (clkEn && ctl_reg[18:16] == 3'h0 && !ctl_reg[5] && !ctl_reg[7]
      |=> laneTxData == $past(txUserData))
      else $error("user word not passed");
   disp_copy_a: assert property (clkEn |=> lane0ByteDisparityFlags == $past(rxDisparityIn))
      else $error("disparity flags wrong");
   inval_copy_a: assert property (clkEn |=> lane0ByteInvalidCodeFlags == $past(rxInvalidCodeIn))
      else $error("invalid code flags wrong");
   comma_copy_a: assert property (clkEn |=> lane0CommaFound == $past(rxCommaIn))
      else $error("comma flag wrong");
   eq_start_a: assert property ($fell(ctl_reg[0]) |-> ##[1:3] lane0EqualizerResetStart)
      else $error("no equalizer reset start");
   freeze_follow_a: assert property ($rose(ctl_reg[6]) |-> ##[1:3] lane0RecoveryLoopFreeze)
      else $error("recovery loop not frozen");
   cover property (lane0EqualizerResetStart);
   cover property (ctl_reg[7] && ctl_reg[18:16] != 3'h0);
   cover property (ctl_reg[5] && clkEn);
endmodule
`default_nettype wire

/* File: bench/lts_lane_model.sv */
// Purpose: far side of the lane, a wire loop from transmit to receive
// Assumes: one word of delay through serialiser and deserialiser
// Notes:   never corrupts data on its own
`timescale 1ns/1ps
`default_nettype none
module lts_lane_model (
   input wire logic clk,
   input wire logic [31:0] laneTxData,
   output logic [31:0] laneRxData
);
   initial laneRxData = 32'h0;
   // returns the sent word one cycle later
   always @(posedge clk) begin
      laneRxData <= laneTxData;
   end
endmodule
`default_nettype wire

/* File: bench/lts_lane_test_status_tb.sv */
// Purpose: self-checking bench for the lane test and status block
// Assumes: zero-wait apb slave, lane looped back by the model
// Notes:   random user words and status flags run in the background
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module lts_lane_test_status_tb;
   import lts_pkg::*;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic flagsOn = 1'b1, pulseComma = 1'b0, rxCommaIn = 1'b0, err;
   logic [7:0] paddr = 8'h00, lane0HighBoost, lane0LowBoost;
   logic [31:0] pwdata = 32'h0, txUserData = 32'h0, prdata, laneTxData, laneRxData, rd, d;
   logic [3:0] rxDisparityIn = 4'h0, rxInvalidCodeIn = 4'h0, pulses;
   logic [3:0] lane0ByteDisparityFlags, lane0ByteInvalidCodeFlags;
   logic pready, pslverr, irq, lane0EqualizerResetStart, lane0RecoveryLoopFreeze;
   logic lane0PatternErrorFlag, lane0CommaFound;
   logic [2:0] s;
   int fails = 0, cmp_count = 0, n;
   always #5 clk = ~clk;
   lts_lane_test_status #(.HIGH_BOOST_ATTR(8'h5A), .LOW_BOOST_ATTR(8'hA5)) i_dut (.clk, .rst_b,
      .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .txUserData, .laneTxData, .laneRxData, .rxDisparityIn, .rxInvalidCodeIn, .rxCommaIn,
      .lane0EqualizerResetStart, .lane0HighBoost, .lane0LowBoost, .lane0RecoveryLoopFreeze,
      .lane0PatternErrorFlag, .lane0ByteDisparityFlags, .lane0ByteInvalidCodeFlags,
      .lane0CommaFound);
   lts_lane_model i_lane (.clk, .laneTxData, .laneRxData);
   // background user words and decoder flags
   always @(posedge clk) begin
      txUserData <= $urandom;
      rxDisparityIn <= flagsOn ? 4'($urandom) : 4'h0;
      rxInvalidCodeIn <= flagsOn ? 4'($urandom) : 4'h0;
      rxCommaIn <= flagsOn ? 1'($urandom) : pulseComma;
   end
   // ==========================================================
   // bus tasks, entered at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      // wait for the answer; only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask
   task automatic wait_n(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(18489));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      `CHK("boost reset", 8'h5A, lane0HighBoost)
      rdchk(LTS_OFF_CTRL, 32'h0, "ctrl reset");
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", 1'b1, err)
      for (n = 0; n < 6; n++) begin
         d = $urandom & 32'hFFFF_FFFE;
         apb(1'b1, LTS_OFF_CTRL, d);
         rdchk(LTS_OFF_CTRL, d & LTS_CTRL_MASK, "ctrl rw");
      end
      flagsOn <= 1'b0;
      apb(1'b1, LTS_OFF_BOOST, 32'h0000_C33C);
      apb(1'b1, LTS_OFF_CTRL, 32'h14);
      wait_n(4);
      `CHK("high live", 8'h3C, lane0HighBoost)
      `CHK("low live", 8'hC3, lane0LowBoost)
      apb(1'b1, LTS_OFF_CTRL, 32'h1E);
      apb(1'b1, LTS_OFF_BOOST, 32'h0000_1234);
      wait_n(4);
      `CHK("high held", 8'h3C, lane0HighBoost)
      apb(1'b1, LTS_OFF_CTRL, 32'h0);
      wait_n(4);
      `CHK("low attribute", 8'hA5, lane0LowBoost)
      apb(1'b1, LTS_OFF_CTRL, 32'h60);
      wait_n(4);
      `CHK("tx blocked", 32'h0, laneTxData)
      `CHK("loop frozen", 1'b1, lane0RecoveryLoopFreeze)
      apb(1'b1, LTS_OFF_CTRL, 32'h1);
      apb(1'b1, LTS_OFF_CTRL, 32'h0);
      pulses = 4'h0;
      repeat (6) begin
         @(posedge clk);
         pulses = pulses + 4'(lane0EqualizerResetStart);
      end
      `CHK("eq pulses", 4'h1, pulses)
      // every pattern, first synced with the count held clear
      for (n = 1; n <= 4; n++) begin
         s = 3'(n);
         apb(1'b1, LTS_OFF_CTRL, {9'h0, s, 1'b0, s, 16'h0100});
         wait_n(40);
         apb(1'b1, LTS_OFF_CTRL, {9'h0, s, 1'b0, s, 16'h0000});
         wait_n(20);
         rdchk(LTS_OFF_ERRCNT, 32'h0, "clean count");
         `CHK("clean flag", 1'b0, lane0PatternErrorFlag)
         apb(1'b1, LTS_OFF_CTRL, {9'h0, s, 1'b0, s, 16'h0080});
         wait_n(6);
         `CHK("error flag", 1'b1, lane0PatternErrorFlag)
         apb(1'b1, LTS_OFF_CTRL, {9'h0, s, 1'b0, s, 16'h0000});
         wait_n(40);
         `CHK("flag drops", 1'b0, lane0PatternErrorFlag)
         apb(1'b0, LTS_OFF_ERRCNT, 32'h0);
         `CHK("counted", 1'b1, rd != 32'h0)
         apb(1'b1, LTS_OFF_CTRL, 32'h100);
         rdchk(LTS_OFF_ERRCNT, 32'h0, "cleared");
      end
      // comma event: masked, unmasked, then cleared
      apb(1'b1, LTS_OFF_CTRL, 32'h0);
      apb(1'b1, LTS_OFF_IRQST, 32'hF);
      pulseComma <= 1'b1;
      @(posedge clk);
      pulseComma <= 1'b0;
      wait_n(4);
      `CHK("irq masked", 1'b0, irq)
      rdchk(LTS_OFF_IRQST, 32'h8, "comma event");
      apb(1'b1, LTS_OFF_IRQMASK, 32'h8);
      wait_n(2);
      `CHK("irq on", 1'b1, irq)
      apb(1'b1, LTS_OFF_IRQST, 32'h8);
      wait_n(2);
      `CHK("irq off", 1'b0, irq)
      tally_and_finish();
   end
   // hang guard, well beyond the several hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule
bind lts_lane_test_status lts_lane_test_status_asserts i_chk (.clk, .rst_b, .clkEn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .txUserData, .laneTxData,
   .rxDisparityIn, .rxInvalidCodeIn, .rxCommaIn, .lane0EqualizerResetStart,
   .lane0RecoveryLoopFreeze, .lane0ByteDisparityFlags, .lane0ByteInvalidCodeFlags,
   .lane0CommaFound);
`default_nettype wire
